// *** logic/adcsc_pkg.sv ***
// Shared constants and types of the serial conversion controller.
// Assumes a 50 MHz system clock; pins are synchronised inside the controller.
package adcsc_pkg;
    localparam int CLK_HZ = 50_000_000;
    localparam int INT_CONV_NS = 25_000;
    localparam int INT_CONV_CYCLES = INT_CONV_NS / (1_000_000_000 / CLK_HZ);
    localparam int TIMER_W = 16;
    localparam int RESULT_W = 8;
    localparam int FIFO_DEPTH = 4;

    // Control byte field positions
    localparam int CTRL_START_POS = 7;
    localparam int CTRL_CHAN_HI_POS = 6;
    localparam int CTRL_CHAN_LO_POS = 4;
    localparam int CTRL_POL_POS = 3;
    localparam int CTRL_CFG_POS = 2;
    localparam int CTRL_PWR_POS = 1;
    localparam int CTRL_CLK_POS = 0;

    // Counts of serial clock edges
    localparam logic [3:0] CTRL_LAST_BIT = 4'h7;
    localparam logic [3:0] EXT_MSB_FALL = 4'h1;
    localparam logic [3:0] EXT_LAST_FALL = 4'h9;
    localparam logic [3:0] INT_MSB_FALL = 4'h1;

    // Reset values
    localparam logic RST_EXT_MODE = 1'b0;
    localparam logic RST_STROBE = 1'b1;
    localparam logic [7:0] RST_CTRL = 8'h00;

    typedef enum {ADCSC_HUNT, ADCSC_COLLECT} adcsc_in_state_t;
    typedef enum {ADCSC_IDLE, ADCSC_EXT, ADCSC_INT, ADCSC_INTREAD} adcsc_cv_state_t;

    typedef struct packed {
        logic [2:0] channel;
        logic polarity_select;
        logic input_config_select;
    } adcsc_cfg_t;
endpackage

// *** logic/adcsc_fifo.sv ***
// Small result FIFO between the converter core and the sequencer.
// Assumes one clock and a synchronous handshake on both sides.
`timescale 1ns/1ps
module adcsc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic push;
    logic pop;

    assign in_ready = (count_reg != (AW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data = mem_reg[rd_ptr_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            // Pointers wrap; depth is expected to be a power of two
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule

// *** logic/adcsc_ctrl.sv ***
// Serial interface and conversion sequencer of an 8-bit multi-channel ADC.
// Assumes pins come from a slow serial master and an abstract converter core.
// Operation
// - Control byte all ones: top channel, single-ended, unipolar, external clock, stay powered.
// - External mode: strobe high two serial periods after last control bit.
// - A conversion takes at least ten serial clocks, also the repeat period.
// - Data output changes only on serial clock falling edges; so does the external mode strobe while chip select is low.
// - With chip select low, data in is sampled on serial clock rising edges.
// - Leading zeros ignored; first one is control bit 7 framing seven more.
// - Returned bytes two and three: two zeros, eight result bits, six zeros.
// - Result MSB first; straight binary unipolar, two's complement bipolar.
// - Clock source bit picks conversion clock; serial clock always shifts data.
// - External mode: eight result bits on next eight falling edges, then zeros.
// - External mode: chip select high floats outputs; strobe driven low after fall.
// - Internal mode: strobe falls at conversion start, rises at completion.
// - Internal mode: result held; MSB on second falling edge after strobe rises.
// - Internal mode: chip select high blocks input, floats data, keeps strobe and conversion.
// - Conversion starts on falling edge after eighth control bit, not chip select.
// - Start bit accepted when idle or after running conversion's MSB was driven.
// - Chip select toggle mid-conversion abandons an external one; in either mode the next one is a start bit.
// - Control bit 0: one serial clock conversion, zero internal oscillator.
// - Bit 1 power state, bits 6-4 channel, bit 3 polarity, bit 2 configuration.
// - After reset: internal mode, strobe high, zeros shifted out.
`timescale 1ns/1ps
module adcsc_ctrl
    import adcsc_pkg::*;
#(
    parameter int INT_CYCLES = INT_CONV_CYCLES,
    parameter int FIFO_WORDS = FIFO_DEPTH
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic din,
    output logic dout,
    output logic dout_oe,
    output logic conversion_strobe,
    output logic conversion_strobe_oe,
    output logic conv_start,
    output adcsc_cfg_t conv_cfg,
    input wire logic result_valid,
    output logic result_ready,
    input wire logic [RESULT_W-1:0] result_data,
    output logic power_down
);
    logic cs_n_meta_reg, cs_n_sync_reg, cs_n_last_reg;
    logic sclk_meta_reg, sclk_sync_reg, sclk_last_reg;
    logic din_meta_reg, din_sync_reg;
    adcsc_in_state_t in_state_reg;
    adcsc_cv_state_t cv_state_reg;
    logic [7:0] in_shift_reg;
    logic [3:0] in_cnt_reg;
    logic [7:0] ctrl_byte_reg;
    logic ctrl_pending_reg, cs_toggled_reg, ext_mode_reg, pwr_keep_reg;
    logic [3:0] fall_cnt_reg;
    logic [TIMER_W-1:0] timer_reg;
    logic [RESULT_W-1:0] result_reg, out_shift_reg;
    logic have_result_reg, msb_driven_reg;
    logic strobe_reg, strobe_oe_reg, dout_oe_reg, conv_start_reg;
    adcsc_cfg_t cfg_reg;
    logic power_down_reg, fifo_valid, fifo_ready;
    logic [RESULT_W-1:0] fifo_data;
    logic sclk_rise, sclk_fall, cs_rise, cs_fall, cs_low;
    logic start_ok, start_seen, ctrl_done, conv_go;
    logic timer_done, ext_done, int_done;
    logic [RESULT_W-1:0] coded_result;

    // Pin synchronisers; edges are found on the second stage only
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cs_n_meta_reg <= 1'b1;
            cs_n_sync_reg <= 1'b1;
            cs_n_last_reg <= 1'b1;
            sclk_meta_reg <= 1'b0;
            sclk_sync_reg <= 1'b0;
            sclk_last_reg <= 1'b0;
            din_meta_reg <= 1'b0;
            din_sync_reg <= 1'b0;
        end else begin
            cs_n_meta_reg <= cs_n;
            cs_n_sync_reg <= cs_n_meta_reg;
            cs_n_last_reg <= cs_n_sync_reg;
            sclk_meta_reg <= sclk;
            sclk_sync_reg <= sclk_meta_reg;
            sclk_last_reg <= sclk_sync_reg;
            din_meta_reg <= din;
            din_sync_reg <= din_meta_reg;
        end
    end

    assign sclk_rise = sclk_sync_reg && !sclk_last_reg;
    assign sclk_fall = !sclk_sync_reg && sclk_last_reg;
    assign cs_rise = cs_n_sync_reg && !cs_n_last_reg;
    assign cs_fall = !cs_n_sync_reg && cs_n_last_reg;
    assign cs_low = !cs_n_sync_reg;

    assign start_ok = (cv_state_reg == ADCSC_IDLE) || msb_driven_reg || cs_toggled_reg;
    assign start_seen = sclk_rise && cs_low && in_state_reg == ADCSC_HUNT && din_sync_reg && start_ok;
    assign ctrl_done = sclk_rise && cs_low && in_state_reg == ADCSC_COLLECT && in_cnt_reg == CTRL_LAST_BIT;
    assign conv_go = ctrl_pending_reg && sclk_fall;
    assign timer_done = (timer_reg >= TIMER_W'(INT_CYCLES - 1));
    assign ext_done = cv_state_reg == ADCSC_EXT && sclk_fall && !cs_rise && fall_cnt_reg == EXT_LAST_FALL;
    assign int_done = cv_state_reg == ADCSC_INT && timer_done && have_result_reg;
    // Core gives straight binary; bipolar flips the MSB into two's complement
    assign coded_result = {result_reg[RESULT_W-1] ^ !cfg_reg.polarity_select, result_reg[RESULT_W-2:0]};

    // Control byte capture; chip select high holds the shifter still
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            in_state_reg <= ADCSC_HUNT;
            in_shift_reg <= RST_CTRL;
            in_cnt_reg <= 4'h0;
            ctrl_byte_reg <= RST_CTRL;
        end else if (cs_rise) begin
            in_state_reg <= ADCSC_HUNT;
        end else if (sclk_rise && cs_low) begin
            case (in_state_reg)
                ADCSC_HUNT: begin
                    if (start_seen) begin
                        in_shift_reg <= 8'h01;
                        in_cnt_reg <= 4'h1;
                        in_state_reg <= ADCSC_COLLECT;
                    end
                end
                default: begin
                    in_shift_reg <= {in_shift_reg[6:0], din_sync_reg};
                    in_cnt_reg <= in_cnt_reg + 4'h1;
                    if (in_cnt_reg == CTRL_LAST_BIT) begin
                        ctrl_byte_reg <= {in_shift_reg[6:0], din_sync_reg};
                        in_state_reg <= ADCSC_HUNT;
                    end
                end
            endcase
        end
    end

    // A full byte waits for the next falling edge to launch the conversion
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ctrl_pending_reg <= 1'b0;
        end else if (ctrl_done) begin
            ctrl_pending_reg <= 1'b1;
        end else if (conv_go || cs_rise) begin
            ctrl_pending_reg <= 1'b0;
        end
    end

    // Set wins over clear so a toggle at launch is not lost
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cs_toggled_reg <= 1'b0;
        end else if (cs_rise) begin
            cs_toggled_reg <= 1'b1;
        end else if (conv_go) begin
            cs_toggled_reg <= 1'b0;
        end
    end

    // Settings latched at launch and handed to the converter core
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ext_mode_reg <= RST_EXT_MODE;
            pwr_keep_reg <= 1'b1;
            cfg_reg <= '0;
            conv_start_reg <= 1'b0;
        end else begin
            conv_start_reg <= conv_go;
            if (conv_go) begin
                ext_mode_reg <= ctrl_byte_reg[CTRL_CLK_POS];
                pwr_keep_reg <= ctrl_byte_reg[CTRL_PWR_POS];
                cfg_reg.channel <= ctrl_byte_reg[CTRL_CHAN_HI_POS:CTRL_CHAN_LO_POS];
                cfg_reg.polarity_select <= ctrl_byte_reg[CTRL_POL_POS];
                cfg_reg.input_config_select <= ctrl_byte_reg[CTRL_CFG_POS];
            end
        end
    end

    // Sequencer: strobe, edge counts, internal timer and output shifter
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cv_state_reg <= ADCSC_IDLE;
            fall_cnt_reg <= 4'h0;
            timer_reg <= '0;
            strobe_reg <= RST_STROBE;
            msb_driven_reg <= 1'b0;
            out_shift_reg <= '0;
        end else if (conv_go) begin
            fall_cnt_reg <= 4'h0;
            timer_reg <= '0;
            msb_driven_reg <= 1'b0;
            out_shift_reg <= {out_shift_reg[RESULT_W-2:0], 1'b0};
            if (ctrl_byte_reg[CTRL_CLK_POS]) begin
                cv_state_reg <= ADCSC_EXT;
                strobe_reg <= 1'b1;
            end else begin
                cv_state_reg <= ADCSC_INT;
                strobe_reg <= 1'b0;
            end
        end else begin
            case (cv_state_reg)
                ADCSC_EXT: begin
                    if (cs_rise) begin
                        cv_state_reg <= ADCSC_IDLE;
                        strobe_reg <= 1'b0;
                    end else if (sclk_fall) begin
                        fall_cnt_reg <= fall_cnt_reg + 4'h1;
                        if (fall_cnt_reg == EXT_MSB_FALL) begin
                            strobe_reg <= 1'b0;
                            out_shift_reg <= coded_result;
                            msb_driven_reg <= 1'b1;
                        end else begin
                            out_shift_reg <= {out_shift_reg[RESULT_W-2:0], 1'b0};
                        end
                        if (fall_cnt_reg == EXT_LAST_FALL) begin
                            cv_state_reg <= ADCSC_IDLE;
                        end
                    end
                end
                ADCSC_INT: begin
                    // Chip select does not stop the timer
                    if (!timer_done) begin
                        timer_reg <= timer_reg + 1'b1;
                    end else if (have_result_reg) begin
                        strobe_reg <= 1'b1;
                        fall_cnt_reg <= 4'h0;
                        cv_state_reg <= ADCSC_INTREAD;
                    end
                    if (sclk_fall && cs_low) begin
                        out_shift_reg <= {out_shift_reg[RESULT_W-2:0], 1'b0};
                    end
                end
                ADCSC_INTREAD: begin
                    if (sclk_fall && cs_low) begin
                        fall_cnt_reg <= fall_cnt_reg + 4'h1;
                        if (fall_cnt_reg == INT_MSB_FALL) begin
                            out_shift_reg <= coded_result;
                            msb_driven_reg <= 1'b1;
                            cv_state_reg <= ADCSC_IDLE;
                        end else begin
                            out_shift_reg <= {out_shift_reg[RESULT_W-2:0], 1'b0};
                        end
                    end
                end
                default: begin
                    if (ext_mode_reg && cs_fall) begin
                        strobe_reg <= 1'b0;
                    end
                    if (sclk_fall && cs_low) begin
                        out_shift_reg <= {out_shift_reg[RESULT_W-2:0], 1'b0};
                    end
                end
            endcase
        end
    end

    // Result register; a late result from an abandoned conversion is not filtered
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            result_reg <= '0;
            have_result_reg <= 1'b0;
        end else if (conv_go) begin
            have_result_reg <= 1'b0;
        end else if (fifo_valid && fifo_ready) begin
            result_reg <= fifo_data;
            have_result_reg <= 1'b1;
        end
    end

    // No pop at launch, so the clear of the result flag never swallows a word
    assign fifo_ready = (cv_state_reg == ADCSC_EXT || cv_state_reg == ADCSC_INT) && !have_result_reg && !conv_go;

    // Output enables: data floats with chip select high in both modes
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            dout_oe_reg <= 1'b0;
            strobe_oe_reg <= 1'b1;
        end else begin
            dout_oe_reg <= cs_low;
            if (conv_go || !ext_mode_reg) begin
                strobe_oe_reg <= 1'b1;
            end else if (cs_rise) begin
                strobe_oe_reg <= 1'b0;
            end else if (cs_fall) begin
                strobe_oe_reg <= 1'b1;
            end
        end
    end

    // Set on completion wins over clear by a new start bit in the same cycle
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            power_down_reg <= 1'b0;
        end else if ((ext_done || int_done) && !pwr_keep_reg) begin
            power_down_reg <= 1'b1;
        end else if (start_seen) begin
            power_down_reg <= 1'b0;
        end
    end

    adcsc_fifo #(
        .WIDTH(RESULT_W),
        .DEPTH(FIFO_WORDS)
    ) u_fifo (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .in_valid(result_valid),
        .in_ready(result_ready),
        .in_data(result_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_ready),
        .out_data(fifo_data)
    );

    assign dout = out_shift_reg[RESULT_W-1];
    assign dout_oe = dout_oe_reg;
    assign conversion_strobe = strobe_reg;
    assign conversion_strobe_oe = strobe_oe_reg;
    assign conv_start = conv_start_reg;
    assign conv_cfg = cfg_reg;
    assign power_down = power_down_reg;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    sequence ext_launch_s;
        conv_go && ctrl_byte_reg[CTRL_CLK_POS];
    endsequence

    sequence strobe_high_two_s;
        cv_state_reg == ADCSC_EXT && fall_cnt_reg <= EXT_MSB_FALL;
    endsequence

    chk_strobe_ext_rise: assert property (ext_launch_s |=> strobe_reg && cv_state_reg == ADCSC_EXT)
        else $error("strobe not raised at external launch");
    chk_strobe_ext_hold: assert property (strobe_high_two_s |-> strobe_reg)
        else $error("strobe dropped before two serial periods");
    chk_msb_ext_drive: assert property (cv_state_reg == ADCSC_EXT && sclk_fall && !cs_rise
        && fall_cnt_reg == EXT_MSB_FALL |=> !strobe_reg && dout == coded_result[RESULT_W-1])
        else $error("external MSB not driven as strobe falls");
    chk_dout_on_fall: assert property ($changed(dout) |-> $past(sclk_fall))
        else $error("serial data changed off a falling edge");
    chk_zero_ignored: assert property (in_state_reg == ADCSC_HUNT && sclk_rise && !din_sync_reg
        |=> in_state_reg == ADCSC_HUNT)
        else $error("zero bit left start hunting");
    chk_start_framed: assert property (start_seen |=> in_state_reg == ADCSC_COLLECT && in_cnt_reg == 4'h1)
        else $error("start bit not framed");
    chk_launch_on_fall: assert property (ctrl_done |=> ctrl_pending_reg && !conv_start_reg)
        else $error("conversion launched before falling edge");
    chk_int_strobe_low: assert property (cv_state_reg == ADCSC_INT && !timer_done && !conv_go
        |=> !strobe_reg)
        else $error("internal strobe rose early");
    chk_int_msb_second: assert property (cv_state_reg == ADCSC_INTREAD && sclk_fall && cs_low
        && fall_cnt_reg == INT_MSB_FALL |=> dout == coded_result[RESULT_W-1] && msb_driven_reg)
        else $error("internal MSB not on second falling edge");
    chk_cs_float_ext: assert property (cs_rise && ext_mode_reg && !conv_go |=> !strobe_oe_reg ##1 !dout_oe_reg)
        else $error("outputs not floated on chip select high");
    chk_int_strobe_kept: assert property (!ext_mode_reg |=> strobe_oe_reg)
        else $error("internal mode strobe left undriven");
    chk_ext_abort: assert property (cv_state_reg == ADCSC_EXT && cs_rise && !conv_go
        |=> cv_state_reg == ADCSC_IDLE)
        else $error("conversion not abandoned on chip select toggle");
endmodule

// *** tb/adcsc_core_model.sv ***
// Behavioural converter core that answers each sample request with one result word.
// Assumes the result handshake of the controller; latency is a parameter so slow answers can be tried.
`timescale 1ns/1ps
module adcsc_core_model #(
    parameter int LAT = 3
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic conv_start,
    input wire logic [7:0] value,
    output logic result_valid,
    input wire logic result_ready,
    output logic [7:0] result_data
);
    int wait_cnt;
    logic pend;

    // Data is inverted while not valid so a stale word never looks right
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pend <= 1'b0;
            wait_cnt <= 0;
            result_valid <= 1'b0;
            result_data <= 8'h00;
        end else if (conv_start) begin
            pend <= 1'b1;
            wait_cnt <= LAT;
            result_data <= ~value;
        end else if (pend && wait_cnt == 0) begin
            pend <= 1'b0;
            result_valid <= 1'b1;
            result_data <= value;
        end else if (pend) begin
            wait_cnt <= wait_cnt - 1;
        end else if (result_valid && result_ready) begin
            result_valid <= 1'b0;
            result_data <= ~result_data;
        end
    end
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench: serial master tasks, a core model and a queue-fed output checker.
// Assumes the serial clock runs at 160 ns, edges placed just after system clock edges.
`timescale 1ns/1ps
module tb_top;
    import adcsc_pkg::*;
    logic clk_sys = 1'b0, resetn = 1'b0, cs_n = 1'b1, sclk = 1'b0, din = 1'b0;
    logic dout, dout_oe, conversion_strobe, conversion_strobe_oe, conv_start, result_valid, result_ready, power_down;
    adcsc_cfg_t conv_cfg;
    logic [7:0] result_data, seen_word;
    logic [7:0] core_value = 8'h00;
    logic [7:0] exp_q[$];
    event seen_ev;
    int fail_count = 0, checks = 0, cycles = 0, seed = 42;

    adcsc_ctrl #(.INT_CYCLES(20), .FIFO_WORDS(FIFO_DEPTH)) dut_u (.clk_sys(clk_sys), .resetn(resetn),
        .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout), .dout_oe(dout_oe), .conversion_strobe(conversion_strobe),
        .conversion_strobe_oe(conversion_strobe_oe), .conv_start(conv_start), .conv_cfg(conv_cfg),
        .result_valid(result_valid), .result_ready(result_ready), .result_data(result_data), .power_down(power_down));
    adcsc_core_model core_u (.clk_sys(clk_sys), .resetn(resetn), .conv_start(conv_start), .value(core_value),
        .result_valid(result_valid), .result_ready(result_ready), .result_data(result_data));

    initial begin
        forever #10 clk_sys = ~clk_sys;
    end

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Mode zero framing; data is read late in the high phase because the answer lags the pin by several clocks
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic [7:0] sb);
        for (int i = 7; i >= 0; i--) begin
            din = tx[i];
            repeat (i == 0 ? 54 : 4) @(posedge clk_sys);
            #1 sclk = 1'b1;
            repeat (4) @(posedge clk_sys);
            // A floating pin reads as the inverse so an undriven bit never looks right
            #1 rx[i] = dout_oe ? dout : ~dout;
            sb[i] = conversion_strobe_oe ? conversion_strobe : ~conversion_strobe;
            sclk = 1'b0;
        end
    endtask

    task automatic note(input logic [7:0] seen, input logic [7:0] exp);
        exp_q.push_back(exp);
        seen_word = seen;
        ->seen_ev;
    endtask

    task automatic convert(input logic [7:0] ctrl, input logic [7:0] r);
        logic [7:0] rx, sb, code;
        code = ctrl[3] ? r : {~r[7], r[6:0]};
        core_value = r;
        cs_n = 1'b0;
        xfer(8'h00, rx, sb);
        note(rx, 8'h00);
        xfer(ctrl, rx, sb);
        note(rx, 8'h00);
        if (!ctrl[0]) begin
            cs_n = 1'b1;
            repeat (8) @(posedge clk_sys);
            #1 check("strobe busy", {7'h00, conversion_strobe}, 8'h00);
            for (int n = 0; n < 400 && conversion_strobe !== 1'b1; n++) @(posedge clk_sys);
            #1 check("strobe done", {7'h00, conversion_strobe}, 8'h01);
            check("oe cs high", {6'h00, conversion_strobe_oe, dout_oe}, 8'h02);
            cs_n = 1'b0;
        end
        xfer(8'h00, rx, sb);
        note(rx, {2'b00, code[7:2]});
        if (ctrl[0]) check("strobe pulse", sb, 8'hC0);
        xfer(8'h00, rx, sb);
        note(rx, {code[1:0], 6'h00});
        check("cfg", {3'h0, conv_cfg}, {3'h0, ctrl[6:2]});
        cs_n = 1'b1;
        repeat (8) @(posedge clk_sys);
        #1 check("power", {7'h00, power_down}, {7'h00, ~ctrl[1]});
        if (ctrl[0]) check("oe ext", {6'h00, conversion_strobe_oe, dout_oe}, 8'h00);
    endtask

    initial begin
        forever begin
            @(seen_ev);
            check("dout byte", seen_word, exp_q.pop_front());
        end
    end

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 30000) begin
            fail_count++;
            wrap_up();
        end
    end

    initial begin
        logic [7:0] rnd;
        repeat (5) @(posedge clk_sys);
        #1 resetn = 1'b1;
        check("reset pins", {4'h0, conversion_strobe, conversion_strobe_oe, dout_oe, power_down}, 8'h0C);
        repeat (4) @(posedge clk_sys);
        #1 convert(8'hFF, 8'($random(seed)));
        for (int k = 0; k < 8; k++) begin
            rnd = 8'($random(seed));
            convert({1'b1, rnd[6:2], 2'(k)}, 8'($random(seed)));
        end
        wrap_up();
    end
endmodule
